// File: pvt_pkg.sv
// package: constants for the panel vertical timing and power-on sequencer
package pvt_pkg;
  // power-on enables by vertical sync pulse count
  localparam logic [3:0] VS_CNT_ANALOG = 4'h2;
  localparam logic [3:0] VS_CNT_PUMP   = 4'h3;
  localparam logic [3:0] VS_CNT_PANEL  = 4'h9;
  localparam logic [3:0] VS_CNT_BOOST  = 4'hB;
  // line timing in dot clocks
  localparam logic [10:0] H_TOTAL_DOTS = 11'h334;
  localparam logic [10:0] H_HALF_DOTS  = 11'h19A;
  localparam logic [10:0] H_ACTIVE     = 11'h280;
  // half-line window for field detection
  localparam logic [10:0] H_HALF_TOL   = 11'h040;
  localparam int          DATA_W       = 8;
  // charge-pump clock divider on the system clock
  localparam logic [4:0]  PUMP_DIV     = 5'h0F;
  typedef enum logic [1:0] {PVT_OFF, PVT_RUN} pvt_seq_t;
endpackage

// File: pvt_sync2.sv
// two-flop synchroniser with edge detection after the second stage
`timescale 1ns/1ps
module pvt_sync2
  import pvt_pkg::*;
#(parameter int W = 1)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut,
  output logic      [W-1:0] riseOut,
  output logic      [W-1:0] fallOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= '1;
      sync_ff <= '1;
      last_ff <= '1;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign syncOut = sync_ff;
  assign riseOut = sync_ff & ~last_ff;
  assign fallOut = ~sync_ff & last_ff;
endmodule

// File: pvt_panel_seq.sv
// panel vertical timing front end and power-on sequencer
// Operation
// - analog supply regulation enabled at second vertical sync
// - charge-pump clock starts at third vertical sync
// - panel control and source output start at ninth vertical sync
// - boost switching control starts at eleventh vertical sync
// - shutdown low forces sleep; high lets sleep register decide
// - pixel byte captured on each dot clock rising edge
// - vertical and horizontal syncs are active low
`timescale 1ns/1ps
module pvt_panel_seq
  import pvt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              global_reset_n,
  input  wire logic              shutdown_n,
  input  wire logic              sleepReg,
  input  wire logic              vert_sync_in,
  input  wire logic              horiz_sync_in,
  input  wire logic              dot_clock,
  input  wire logic [DATA_W-1:0] pixelData,
  output logic                   analog_supply_reg,
  output logic                   charge_pump_clock,
  output logic                   panelCtrlEn,
  output logic                   boostPwmEn,
  output logic                   sleepActive,
  output logic                   fieldEven,
  output logic [DATA_W-1:0]      pixelOut,
  output logic                   pixelValid
);
  // pin synchronisers: global reset, shutdown, vsync, hsync, dot clock
  logic [4:0] pinSync;
  logic [4:0] pinRise;
  logic [4:0] pinFall;
  logic [DATA_W-1:0] dataMeta_ff;
  logic [DATA_W-1:0] dataSync_ff;

  pvt_sync2 #(.W(5)) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn ({global_reset_n, shutdown_n, vert_sync_in, horiz_sync_in, dot_clock}),
    .syncOut (pinSync),
    .riseOut (pinRise),
    .fallOut (pinFall)
  );

  wire grstN    = pinSync[4];
  wire shdnN    = pinSync[3];
  wire vsFall   = pinFall[2];
  wire hsFall   = pinFall[1];
  wire dotRise  = pinRise[0];

  logic sleepMeta_ff;
  logic sleepSync_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dataMeta_ff  <= '0;
      dataSync_ff  <= '0;
      sleepMeta_ff <= 1'b1;
      sleepSync_ff <= 1'b1;
    end else begin
      dataMeta_ff  <= pixelData;
      dataSync_ff  <= dataMeta_ff;
      sleepMeta_ff <= sleepReg;
      sleepSync_ff <= sleepMeta_ff;
    end
  end

  // vertical sync counter from global reset release, saturating at boost step
  logic [3:0] vsCnt_ff;
  wire        cntSat   = (vsCnt_ff == VS_CNT_BOOST);
  wire [3:0]  nxt_vsCnt = (!grstN) ? 4'h0 :
                          (vsFall && !cntSat) ? vsCnt_ff + 4'h1 : vsCnt_ff;

  always_ff @(posedge clk) begin
    if (!resetn) vsCnt_ff <= 4'h0;
    else         vsCnt_ff <= nxt_vsCnt;
  end

  // a power-on step holds once the pulse count has reached its number
  function automatic logic pvt_reached(input logic [3:0] cnt, input logic [3:0] stepAt);
    return cnt >= stepAt;
  endfunction

  wire nxt_analog = grstN && pvt_reached(nxt_vsCnt, VS_CNT_ANALOG);
  wire pumpOn     = grstN && pvt_reached(nxt_vsCnt, VS_CNT_PUMP);
  wire nxt_panel  = grstN && pvt_reached(nxt_vsCnt, VS_CNT_PANEL);
  wire nxt_boost  = grstN && pvt_reached(nxt_vsCnt, VS_CNT_BOOST);
  wire nxt_sleep  = !shdnN || sleepSync_ff;

  // charge-pump clock divider
  logic [4:0] pumpDiv_ff;
  logic       pumpClk_ff;
  wire        pumpWrap = (pumpDiv_ff == PUMP_DIV);
  always_ff @(posedge clk) begin
    if (!resetn || !pumpOn) begin
      pumpDiv_ff <= 5'h00;
      pumpClk_ff <= 1'b0;
    end else begin
      pumpDiv_ff <= pumpWrap ? 5'h00 : pumpDiv_ff + 5'h01;
      pumpClk_ff <= pumpWrap ? ~pumpClk_ff : pumpClk_ff;
    end
  end

  logic analog_ff;
  logic panel_ff;
  logic boost_ff;
  logic sleep_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analog_ff <= 1'b0;
      panel_ff  <= 1'b0;
      boost_ff  <= 1'b0;
      sleep_ff  <= 1'b1;
    end else begin
      analog_ff <= nxt_analog;
      panel_ff  <= nxt_panel;
      boost_ff  <= nxt_boost;
      sleep_ff  <= nxt_sleep;
    end
  end

  // dot counter within a line, restarted by horizontal sync
  logic [10:0] dotCnt_ff;
  always_ff @(posedge clk) begin
    if (!resetn)      dotCnt_ff <= 11'h000;
    else if (hsFall)  dotCnt_ff <= 11'h000;
    else if (dotRise && dotCnt_ff != H_TOTAL_DOTS) dotCnt_ff <= dotCnt_ff + 11'h001;
  end

  // vsync landing near mid-line marks the even field
  wire nearHalf = (dotCnt_ff + H_HALF_TOL >= H_HALF_DOTS) &&
                  (dotCnt_ff <= H_HALF_DOTS + H_HALF_TOL);
  logic field_ff;
  always_ff @(posedge clk) begin
    if (!resetn)     field_ff <= 1'b0;
    else if (vsFall) field_ff <= nearHalf;
  end

  // pixel capture on each dot clock rising edge; valid only within active dots while panel is on and awake
  wire pixActive = (dotCnt_ff < H_ACTIVE) && panel_ff && !sleep_ff;
  logic [DATA_W-1:0] pix_ff;
  logic              pixValid_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pix_ff      <= '0;
      pixValid_ff <= 1'b0;
    end else begin
      pixValid_ff <= dotRise && pixActive;
      if (dotRise) pix_ff <= dataSync_ff;
    end
  end

  assign analog_supply_reg = analog_ff;
  assign charge_pump_clock = pumpClk_ff;
  assign panelCtrlEn       = panel_ff;
  assign boostPwmEn        = boost_ff;
  assign sleepActive       = sleep_ff;
  assign fieldEven         = field_ff;
  assign pixelOut          = pix_ff;
  assign pixelValid        = pixValid_ff;

  // power-on order and pulse counts
  analog_order_a: assert property (@(posedge clk) disable iff (!resetn)
    boost_ff |-> panel_ff && analog_ff)
    else $error("boost before panel");
  panel_count_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(panel_ff) |-> vsCnt_ff == VS_CNT_PANEL)
    else $error("panel count");
  analog_count_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(analog_ff) |-> vsCnt_ff == VS_CNT_ANALOG)
    else $error("analog count");
  pump_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    vsCnt_ff < VS_CNT_PUMP |=> !pumpClk_ff)
    else $error("pump early");
  pump_toggle_a: assert property (@(posedge clk) disable iff (!resetn)
    pumpOn && pumpWrap |=> pumpClk_ff != $past(pumpClk_ff))
    else $error("pump not toggling");
  pump_order_a: assert property (@(posedge clk) disable iff (!resetn)
    pumpClk_ff |-> analog_ff)
    else $error("pump before analog");
  boost_count_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(boost_ff) |-> vsCnt_ff == VS_CNT_BOOST)
    else $error("boost count");
  reset_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    !grstN |=> vsCnt_ff == 4'h0 && !analog_ff)
    else $error("reset clear");
  count_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    cntSat && grstN |=> vsCnt_ff == VS_CNT_BOOST)
    else $error("count not saturated");
  // sleep, line and pixel handling
  sleep_force_a: assert property (@(posedge clk) disable iff (!resetn)
    !shdnN |=> sleep_ff)
    else $error("sleep not forced");
  sleep_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    shdnN |=> sleep_ff == $past(sleepSync_ff))
    else $error("sleep bit ignored");
  dot_restart_a: assert property (@(posedge clk) disable iff (!resetn)
    hsFall |=> dotCnt_ff == 11'h000)
    else $error("dot count not restarted");
  field_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    vsFall |=> field_ff == $past(nearHalf))
    else $error("field not latched");
  pix_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    dotRise |=> pix_ff == $past(dataSync_ff))
    else $error("pixel not captured");
  pix_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    pixValid_ff |-> $past(dotRise) && $past(panel_ff) && !$past(sleep_ff))
    else $error("pixel gate");
  cover_boost_c: cover property (@(posedge clk) disable iff (!resetn) $rose(boost_ff));
  cover_even_c: cover property (@(posedge clk) disable iff (!resetn) $rose(field_ff));
  cover_pix_c: cover property (@(posedge clk) disable iff (!resetn) pixValid_ff);
  cover_pump_c: cover property (@(posedge clk) disable iff (!resetn) $rose(pumpClk_ff));
  cover_wake_c: cover property (@(posedge clk) disable iff (!resetn) $fell(sleep_ff));
endmodule

// File: pvt_ctl_model.sv
// display controller model: syncs, dot clock and pixel bytes
`timescale 1ns/1ps
module pvt_ctl_model
  import pvt_pkg::*;
(
  output logic              vSyncN,
  output logic              hSyncN,
  output logic              dotClk,
  output logic [DATA_W-1:0] pixByte
);
  // lines stay still until a frame is sent
  initial begin
    vSyncN = 1'b1;
    hSyncN = 1'b1;
    dotClk = 1'b0;
    pixByte = 8'h00;
  end
  // byte stands around the rising edge, then turns to its inverse
  task automatic dot(input logic [DATA_W-1:0] b);
    pixByte = b;
    #18 dotClk = 1'b1;
    #24 dotClk = 1'b0;
    #6 pixByte = ~b;
  endtask
  task automatic vpulse;
    vSyncN = 1'b0;
    repeat (2) dot(8'h00);
    vSyncN = 1'b1;
    repeat (2) dot(8'h00);
  endtask
  task automatic line(input int vsAt);
    for (int i = 0; i < 820; i++) begin
      hSyncN = (i != 0);
      vSyncN = (i != vsAt);
      dot(DATA_W'(i));
    end
  endtask
endmodule

// File: pvt_panel_seq_bench.sv
// bench for the panel power-on sequencer and vertical timing front end
`timescale 1ns/1ps
module pvt_panel_seq_bench;
  import pvt_pkg::*;
  logic              clk, resetn, gRstN, shutN, sleepIn, vs, hs, dc;
  logic              anaEn, pumpClk, panelEn, boostEn, sleepOn, fieldEv, pixVal;
  logic [DATA_W-1:0] pd, pixOut, lastPix;
  int                n_fail = 0;
  int                comparisons = 0;
  int                nValid = 0;
  // global reset low time at power-on, just over 160 us
  localparam int     GRST_LOW_CYC = 32200;
  pvt_ctl_model ctl (.vSyncN(vs), .hSyncN(hs), .dotClk(dc), .pixByte(pd));
  pvt_panel_seq DUT (.clk(clk), .resetn(resetn), .global_reset_n(gRstN),
    .shutdown_n(shutN), .sleepReg(sleepIn), .vert_sync_in(vs), .horiz_sync_in(hs),
    .dot_clock(dc), .pixelData(pd), .analog_supply_reg(anaEn),
    .charge_pump_clock(pumpClk), .panelCtrlEn(panelEn), .boostPwmEn(boostEn),
    .sleepActive(sleepOn), .fieldEven(fieldEv), .pixelOut(pixOut), .pixelValid(pixVal));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pixVal === 1'b1) begin
      nValid++;
      lastPix = pixOut;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // pump clock must change within 40 cycles when running, never when stopped
  task automatic pump_check(input logic exp);
    logic p;
    logic t;
    p = pumpClk;
    t = 1'b0;
    repeat (40) begin
      step(1);
      if (pumpClk !== p) t = 1'b1;
    end
    check(16'(t), 16'(exp), "pump clock");
  endtask
  task automatic seq_test;
    gRstN = 1'b1;
    // command after the reset pulse clears the sleep bit
    sleepIn = 1'b0;
    step(4);
    for (int k = 1; k <= 12; k++) begin
      ctl.vpulse();
      step(6);
      check(16'(anaEn), 16'(k >= 2), "analog enable");
      check(16'(panelEn), 16'(k >= 9), "panel enable");
      check(16'(boostEn), 16'(k >= 11), "boost enable");
      pump_check(k >= 3);
    end
  endtask
  task automatic sleep_test;
    shutN = 1'b0;
    step(6);
    check(16'(sleepOn), 16'h0001, "forced sleep");
    shutN = 1'b1;
    step(6);
    check(16'(sleepOn), 16'h0000, "awake");
    sleepIn = 1'b1;
    step(6);
    check(16'(sleepOn), 16'h0001, "sleep bit");
    // low-power command: supply stays on for over 8 more vsync periods
    repeat (9) ctl.vpulse();
    step(6);
    check(16'(sleepOn), 16'h0001, "sleep held");
    check(16'(panelEn), 16'h0001, "panel held");
    sleepIn = 1'b0;
    step(6);
  endtask
  task automatic line_test(input int vsAt, input logic awake, input logic expEven);
    shutN = awake;
    step(6);
    nValid = 0;
    ctl.line(vsAt);
    step(8);
    check(16'(nValid), awake ? 16'(H_ACTIVE) : 16'h0000, "valid count");
    if (awake) check(16'(lastPix), 16'h007F, "last pixel");
    check(16'(fieldEv), 16'(expEven), "field");
  endtask
  task automatic reset_test;
    gRstN = 1'b0;
    step(6);
    check(16'({anaEn, panelEn, boostEn}), 16'h0000, "enables cleared");
    pump_check(1'b0);
    gRstN = 1'b1;
    step(4);
    ctl.vpulse();
    step(6);
    check(16'(anaEn), 16'h0000, "first pulse after reset");
    ctl.vpulse();
    step(6);
    check(16'(anaEn), 16'h0001, "second pulse after reset");
  endtask
  initial begin
    #400000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    resetn = 1'b0;
    gRstN = 1'b0;
    shutN = 1'b1;
    sleepIn = 1'b1;
    step(3);
    resetn = 1'b1;
    step(2);
    step(GRST_LOW_CYC);
    seq_test;
    sleep_test;
    line_test(0, 1'b1, 1'b0);
    line_test(410, 1'b1, 1'b1);
    line_test(0, 1'b0, 1'b0);
    reset_test;
    stop_test;
  end
endmodule
